//--- sim/rss_mem_model.sv
// Backing store model that takes spill words from the engine's memory side.
`timescale 1ns/100ps
module rss_mem_model
  import rss_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   holdOff,
  input  wire logic                   memValid,
  output logic                        memReady,
  input  wire logic [SPILL_W-1:0]     memWord
);
  // Words accepted, in arrival order: address, data, privilege, byte order.
  logic [SPILL_W-1:0] words[$];

  ////////////////////////////////////////////////////////////////////////////
  // Ready changes only just after an edge, so a stall lands whole cycles.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      memReady <= 1'b0;
    end
    else
    begin
      memReady <= !holdOff;
    end
  end

  // A word is taken at the edge where valid and ready are both high.
  always_ff @(posedge clk)
  begin
    if (!sys_rst && memValid && memReady)
    begin
      words.push_back(memWord);
    end
  end
endmodule : rss_mem_model

//--- sim/tb_top.sv
// Self-checking testbench of the register stack spill engine.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin errorCnt++; \
  $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module tb_top;
  import rss_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, holdOff = 1'b0, memReady, memValid;
  logic cEfl = 0, cInv = 0, cNew = 0, cPre = 0, cSet = 0, intReq = 0, fault = 0;
  logic [7:0] nfs = 8'h0, psz = 8'h0, dirtyCount, cleanCount, invalidCount, frameSize;
  logic [63:0] nsp = 64'h0, fillP = 64'h0, stackTop, spillPtr, coll, wantD, adr;
  logic [6:0] nextReg, frameBase;
  logic [63:0] regData;
  logic [SPILL_W-1:0] memWord;
  logic cmdReady, spillFaulted, current_frame_load_enable, altInv;
  int errorCnt = 0, nTests = 0;
  localparam logic [63:0] A0 = 64'h11d8;  // Start four slots below a collection slot.
  assign regData = {57'h0a5a5a5, nextReg};  // Register data names its own index.

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 50 MHz.
  always #10 clk = ~clk;

  rss_spill_engine i_rss_spill_engine (.clk(clk), .sys_rst(sys_rst), .cmdEnableFrameLoad(cEfl),
    .cmdInvalidate(cInv), .cmdNewFrame(cNew), .newFrameSize(nfs), .cmdPreserve(cPre), .preserveSize(psz),
    .cmdSetSpillPtr(cSet), .newSpillPtr(nsp), .fillPointer(fillP), .spillPrivilegeLevel(2'h2),
    .spillByteOrder(1'b1), .interruptReq(intReq), .spillFault(fault), .nextSpillRegister(nextReg),
    .regReadData(regData), .regReadToken(nextReg[0]), .cmdReady(cmdReady), .spillFaulted(spillFaulted),
    .currentFrameLoadEnable(current_frame_load_enable), .stackTopPointer(stackTop), .spillPointer(spillPtr),
    .deferredTokenCollection(coll), .dirtyCount(dirtyCount), .cleanCount(cleanCount),
    .invalidCount(invalidCount), .frameSize(frameSize), .frameBase(frameBase), .advLoadTableInval(altInv),
    .memValid(memValid), .memReady(memReady), .memWord(memWord));
  rss_mem_model i_rss_mem_model (.clk(clk), .sys_rst(sys_rst), .holdOff(holdOff), .memValid(memValid),
    .memReady(memReady), .memWord(memWord));

  ////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic giveVerdict();
    $display("comparisons %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : giveVerdict

  // One-cycle command pulse; outputs have settled at the following falling edge.
  task automatic pulse(ref logic c);
    @(negedge clk) c = 1'b1;
    @(negedge clk) c = 1'b0;
  endtask : pulse

  // Waits for the engine to go idle again.
  task automatic wait_ready(int lim);
    int i;
    for (i = 0; i < lim && cmdReady !== 1'b1; i++) @(negedge clk);
    `CHK("cmdReady", 1'b1, cmdReady)
  endtask : wait_ready

  // Partitions and frame always account for every stacked register.
  task automatic chk_sum();
    `CHK("sum", 10'd96, 10'(dirtyCount) + cleanCount + invalidCount + frameSize)
  endtask : chk_sum

  task automatic t_reset();
    `CHK("invalid", 8'd96, invalidCount)
    `CHK("dirty", 8'd0, dirtyCount)
    `CHK("stackTop", 64'h0, stackTop)
    `CHK("ready", 1'b1, cmdReady)
    `CHK("altInv", 1'b0, altInv)
  endtask : t_reset

  // Absolute frame sizes, oversize ignored, then preserve renames.
  task automatic t_frame();
    nfs = 8'd20;
    pulse(cNew);
    pulse(cNew);
    `CHK("frameSize", 8'd20, frameSize)
    `CHK("frameBase", 7'd0, frameBase)
    nfs = 8'd200;
    pulse(cNew);
    `CHK("frameSize", 8'd20, frameSize)
    psz = 8'd12;
    pulse(cPre);
    `CHK("frameBase", 7'd12, frameBase)
    `CHK("dirty", 8'd12, dirtyCount)
    `CHK("stackTop", 64'h60, stackTop)
    chk_sum();
  endtask : t_frame

  // Software rewrite of the spill pointer with twelve dirty registers.
  task automatic t_setptr();
    nsp = A0;
    pulse(cSet);
    `CHK("spillPtr", A0, spillPtr)
    `CHK("stackTop", A0 + 64'd104, stackTop)
    `CHK("clean", 8'd0, cleanCount)
    `CHK("dirty", 8'd12, dirtyCount)
  endtask : t_setptr

  task automatic t_current_frame_load_enable();
    fillP = A0 + 64'd104;
    pulse(cEfl);
    `CHK("current_frame_load_enable", 1'b0, current_frame_load_enable)
    fillP = A0 + 64'd112;
    pulse(cEfl);
    `CHK("current_frame_load_enable", 1'b1, current_frame_load_enable)
    `CHK("memValid", 1'b0, memValid)
    `CHK("ready", 1'b1, cmdReady)
  endtask : t_current_frame_load_enable

  // Forced spill into a stalled buffer, then drain and compare every word.
  task automatic t_spill();
    int i, r;
    holdOff = 1'b1;
    nfs = 8'd96;
    pulse(cNew);
    repeat (20) @(negedge clk);
    `CHK("ready", 1'b0, cmdReady)
    `CHK("spillPtr", A0 + 64'd64, spillPtr)
    `CHK("dirty", 8'd5, dirtyCount)
    `CHK("clean", 8'd7, cleanCount)
    holdOff = 1'b0;
    wait_ready(100);
    for (i = 0; i < 20 && memValid !== 1'b0; i++) @(negedge clk);
    `CHK("count", 13, i_rss_mem_model.words.size())
    adr = A0;
    r = 0;
    for (i = 0; i < 13 && i < i_rss_mem_model.words.size(); i++)
    begin
      wantD = (adr[8:3] == 6'h3f) ? 64'h5000_0000_0000_0000 : {57'h0a5a5a5, 7'(r)};
      if (adr[8:3] != 6'h3f) r++;
      `CHK("word", {adr, wantD, 2'h2, 1'b1}, i_rss_mem_model.words[i])
      adr = adr + 64'h8;
    end
    `CHK("spillPtr", A0 + 64'd104, spillPtr)
    `CHK("coll", 64'h5000_0000_0000_00aa, coll)
    `CHK("frameSize", 8'd96, frameSize)
    chk_sum();
  endtask : t_spill

  // Invalidate, then interrupted and faulting spill sequences.
  task automatic t_intr();
    int i;
    logic [63:0] sp;
    nfs = 8'd20;
    pulse(cNew);
    psz = 8'd12;
    pulse(cPre);
    pulse(cInv);
    `CHK("dirty", 8'd0, dirtyCount)
    `CHK("invalid", 8'd88, invalidCount)
    psz = 8'd8;
    pulse(cPre);
    intReq = 1'b1;
    nfs = 8'd96;
    pulse(cNew);
    wait_ready(10);
    `CHK("dirty", 8'd8, dirtyCount)
    `CHK("frameSize", 8'd0, frameSize)
    chk_sum();
    intReq = 1'b0;
    fault = 1'b1;
    sp = spillPtr;
    pulse(cNew);
    for (i = 0; i < 10 && spillFaulted !== 1'b1; i++) @(negedge clk);
    `CHK("faulted", 1'b1, spillFaulted)
    fault = 1'b0;
    wait_ready(10);
    `CHK("spillPtr", sp, spillPtr)
  endtask : t_intr

  initial
  begin
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_frame();
    t_setptr();
    t_current_frame_load_enable();
    t_spill();
    t_intr();
    giveVerdict();
  end

  // Watchdog well beyond the fewer than a hundred cycles the tests take.
  initial
  begin
    #100us;
    errorCnt++;
    giveVerdict();
  end
endmodule : tb_top

//--- verilog/rss_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/100ps
module rss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  rss_fifo_if.snk               inSide,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("rss_fifo depth must be a power of two of at least two.");
  end

  logic [WIDTH-1:0] memQ [DEPTH];  // Storage words.
  logic [AW:0]      wrPtrQ;        // Write pointer with wrap bit.
  logic [AW:0]      rdPtrQ;        // Read pointer with wrap bit.
  logic             fullW;         // No room left.
  logic             emptyW;        // Nothing stored.

  assign emptyW       = (wrPtrQ == rdPtrQ);
  assign fullW        = (wrPtrQ[AW] != rdPtrQ[AW]) && (wrPtrQ[AW-1:0] == rdPtrQ[AW-1:0]);
  assign inSide.ready = !fullW;
  assign outValid     = !emptyW;
  assign outData      = memQ[rdPtrQ[AW-1:0]];

  ////////////////////////////////////////////////////////////////////////////
  // Writes store the offered word while room remains.
  always_ff @(posedge clk)
  begin
    if (inSide.valid && !fullW)
      memQ[wrPtrQ[AW-1:0]] <= inSide.data;
  end

  // Pointers advance on each accepted push and pop.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
    end
    else
    begin
      if (inSide.valid && !fullW)
        wrPtrQ <= wrPtrQ + 1'b1;
      if (outReady && !emptyW)
        rdPtrQ <= rdPtrQ + 1'b1;
    end
  end
endmodule : rss_fifo

//--- verilog/rss_fifo_if.sv
// Valid/ready link that carries spill words between the engine and its buffer.
`timescale 1ns/100ps
interface rss_fifo_if #(
  parameter int WIDTH = 8
);
  logic             valid;  // Producer offers a word.
  logic             ready;  // Consumer takes the word this cycle.
  logic [WIDTH-1:0] data;   // The offered word.
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : rss_fifo_if

//--- verilog/rss_pkg.sv
// Shared constants and types for the register stack spill engine.
package rss_pkg;
  localparam int          ADDR_W      = 64;     // Backing store address width.
  localparam int          DATA_W      = 64;     // Width of one spilled general register.
  localparam int          PL_W        = 2;      // Width of the spill privilege level field.
  localparam int          STK_REGS    = 96;     // Implemented stacked general registers.
  localparam int          FIFO_DEPTH  = 8;      // Words buffered toward the memory side.
  localparam int          SLOT_LSB    = 3;      // Low bit of the collection slot index in an address.
  localparam int          SLOT_MSB    = 8;      // High bit of the collection slot index in an address.
  localparam int          SLOT_W      = SLOT_MSB - SLOT_LSB + 1;
  localparam logic [5:0]  COLL_SLOT   = 6'h3f;  // Slot index that holds the token collection word.
  localparam logic [8:0]  SLOTS_GROUP = 9'h03f; // Register slots between two collection words.
  localparam logic [63:0] WORD_BYTES  = 64'h8;  // Byte step of the spill pointer.
  localparam int          WORD_SHIFT  = 3;      // Log2 of the byte step.
  localparam logic [63:0] TOKEN_RST   = 64'h0;  // Reset value of the token collection.
  localparam logic [63:0] PTR_RST     = 64'h0;  // Reset value of both stack pointers.
  // Word pushed toward the backing store: address, data, privilege and byte order.
  localparam int          SPILL_W     = ADDR_W + DATA_W + PL_W + 1;
  // Engine sequencer states, one-hot.
  typedef enum logic [1:0] {
    RSS_IDLE  = 2'b01,
    RSS_SPILL = 2'b10
  } rss_state_t;
endpackage : rss_pkg

//--- verilog/rss_spill_engine.sv
// Register stack engine that spills stacked registers to the backing store.
`timescale 1ns/100ps
module rss_spill_engine
  import rss_pkg::*;
#(
  parameter int NSTK  = rss_pkg::STK_REGS,
  parameter int DEPTH = rss_pkg::FIFO_DEPTH
) (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic                         cmdEnableFrameLoad,
  input  wire logic                         cmdInvalidate,
  input  wire logic                         cmdNewFrame,
  input  wire logic [7:0]                   newFrameSize,
  input  wire logic                         cmdPreserve,
  input  wire logic [7:0]                   preserveSize,
  input  wire logic                         cmdSetSpillPtr,
  input  wire logic [rss_pkg::ADDR_W-1:0]   newSpillPtr,
  input  wire logic [rss_pkg::ADDR_W-1:0]   fillPointer,
  input  wire logic [rss_pkg::PL_W-1:0]     spillPrivilegeLevel,
  input  wire logic                         spillByteOrder,
  input  wire logic                         interruptReq,
  input  wire logic                         spillFault,
  output logic [6:0]                        nextSpillRegister,
  input  wire logic [rss_pkg::DATA_W-1:0]   regReadData,
  input  wire logic                         regReadToken,
  output logic                              cmdReady,
  output logic                              spillFaulted,
  output logic                              currentFrameLoadEnable,
  output logic [rss_pkg::ADDR_W-1:0]        stackTopPointer,
  output logic [rss_pkg::ADDR_W-1:0]        spillPointer,
  output logic [63:0]                       deferredTokenCollection,
  output logic [7:0]                        dirtyCount,
  output logic [7:0]                        cleanCount,
  output logic [7:0]                        invalidCount,
  output logic [7:0]                        frameSize,
  output logic [6:0]                        frameBase,
  output logic                              advLoadTableInval,
  output logic                              memValid,
  input  wire logic                         memReady,
  output logic [rss_pkg::SPILL_W-1:0]       memWord
);
  import rss_pkg::*;

  initial
  begin
    if (NSTK < 2 || NSTK > 127)
      $error("rss_spill_engine supports 2 to 127 stacked registers.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Adds n to a stacked register index, wrapping within the stack.
  function automatic logic [6:0] wrapAdd(input logic [6:0] idx, input logic [7:0] n);
    logic [8:0] sum;
    sum = {2'b00, idx} + {1'b0, n};
    if (sum >= 9'(NSTK))
      sum = sum - 9'(NSTK);
    return sum[6:0];
  endfunction : wrapAdd

  // Address reached after n register slots, skipping collection words crossed.
  function automatic logic [63:0] addSlots(input logic [63:0] a, input logic [7:0] n);
    logic [8:0] total;
    total = {1'b0, n} + (({3'b000, a[SLOT_MSB:SLOT_LSB]} + {1'b0, n}) / SLOTS_GROUP);
    return a + (64'(total) << WORD_SHIFT);
  endfunction : addSlots

  ////////////////////////////////////////////////////////////////////////////
  // State.

  rss_state_t  stateQ;        // Sequencer state.
  logic [7:0]  pendSizeQ;     // Frame size waiting for room during forced spills.
  logic        faultQ;        // One-cycle fault report.
  logic [5:0]  slotW;         // Collection slot of the current spill address.
  logic        collSlotW;     // Current spill address is the collection word.
  logic [7:0]  growW;         // Registers still missing for a pending frame.
  logic        roomW;         // Invalid plus clean cover the pending growth.
  logic        pushW;         // A spill word is offered this cycle.
  logic        pushTakenW;    // The buffer took the spill word.
  logic [7:0]  fromInvW;      // Growth covered by invalid registers.
  logic        idleW;         // Commands are accepted.

  assign slotW      = spillPointer[SLOT_MSB:SLOT_LSB];
  assign collSlotW  = (slotW == COLL_SLOT);
  assign growW      = (pendSizeQ > frameSize) ? (pendSizeQ - frameSize) : 8'h00;
  assign roomW      = ({1'b0, invalidCount} + {1'b0, cleanCount}) >= {1'b0, growW};
  assign fromInvW   = (invalidCount >= growW) ? growW : invalidCount;
  assign idleW      = (stateQ == RSS_IDLE);
  assign cmdReady   = idleW;
  assign spillFaulted      = faultQ;
  assign nextSpillRegister = wrapAdd(frameBase, 8'(NSTK) - dirtyCount);
  // Only dirty registers, which lie below the frame, and collection words are ever offered.
  assign pushW      = (stateQ == RSS_SPILL) && !roomW && !interruptReq && !spillFault
                      && (collSlotW || dirtyCount != 8'h00);
  // Spill writes carry no request to clear advanced load entries.
  assign advLoadTableInval = 1'b0;

  rss_fifo_if #(.WIDTH(SPILL_W)) pushIf ();

  // Spill word: address, data, then the configured privilege and byte order.
  assign pushIf.valid = pushW;
  assign pushIf.data  = {spillPointer, (collSlotW ? deferredTokenCollection : regReadData),
                         spillPrivilegeLevel, spillByteOrder};
  assign pushTakenW   = pushW && pushIf.ready;

  rss_fifo #(.WIDTH(SPILL_W), .DEPTH(DEPTH)) spillBuf (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inSide   (pushIf),
    .outValid (memValid),
    .outReady (memReady),
    .outData  (memWord)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: a growing frame without room enters forced spilling.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      stateQ    <= RSS_IDLE;
      pendSizeQ <= 8'h00;
      faultQ    <= 1'b0;
    end
    else
    begin
      faultQ <= 1'b0;
      case (stateQ)
        RSS_IDLE:
        begin
          // Oversized frames are ignored rather than spilling forever.
          if (!cmdSetSpillPtr && !cmdInvalidate && !cmdPreserve && cmdNewFrame
              && newFrameSize <= 8'(NSTK) && newFrameSize > frameSize
              && ({1'b0, invalidCount} + {1'b0, cleanCount}) < {1'b0, newFrameSize - frameSize})
          begin
            stateQ    <= RSS_SPILL;
            pendSizeQ <= newFrameSize;
          end
        end
        RSS_SPILL:
        begin
          // Room reached, interrupted, or a spill faulted: stop the sequence.
          if (roomW || interruptReq)
            stateQ <= RSS_IDLE;
          else if (spillFault)
          begin
            stateQ <= RSS_IDLE;
            faultQ <= 1'b1;
          end
        end
        default:
          stateQ <= RSS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Partition counters, frame size and frame base.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dirtyCount   <= 8'h00;
      cleanCount   <= 8'h00;
      invalidCount <= 8'(NSTK);
      frameSize    <= 8'h00;
      frameBase    <= 7'h00;
    end
    else if (idleW && cmdSetSpillPtr)
    begin
      // Dirty size is kept; clean registers lose their backing copy.
      invalidCount <= invalidCount + cleanCount;
      cleanCount   <= 8'h00;
    end
    else if (idleW && cmdInvalidate)
    begin
      invalidCount <= invalidCount + cleanCount + dirtyCount;
      cleanCount   <= 8'h00;
      dirtyCount   <= 8'h00;
    end
    else if (idleW && cmdPreserve && preserveSize <= frameSize)
    begin
      // The preserved registers become dirty and the base moves past them.
      frameBase  <= wrapAdd(frameBase, preserveSize);
      frameSize  <= frameSize - preserveSize;
      dirtyCount <= dirtyCount + preserveSize;
    end
    else if (idleW && cmdNewFrame && newFrameSize <= 8'(NSTK))
    begin
      // The size is absolute; shrinking frees registers to invalid.
      if (newFrameSize <= frameSize)
      begin
        frameSize    <= newFrameSize;
        invalidCount <= invalidCount + (frameSize - newFrameSize);
      end
      else if ({1'b0, invalidCount} + {1'b0, cleanCount} >= {1'b0, newFrameSize - frameSize})
      begin
        frameSize    <= newFrameSize;
        invalidCount <= invalidCount - ((invalidCount >= newFrameSize - frameSize)
                                        ? (newFrameSize - frameSize) : invalidCount);
        cleanCount   <= cleanCount - ((newFrameSize - frameSize)
                                      - ((invalidCount >= newFrameSize - frameSize)
                                         ? (newFrameSize - frameSize) : invalidCount));
      end
    end
    else if (stateQ == RSS_SPILL && roomW)
    begin
      // Forced spills made room: allocate invalid first, then clean.
      frameSize    <= pendSizeQ;
      invalidCount <= invalidCount - fromInvW;
      cleanCount   <= cleanCount - (growW - fromInvW);
    end
    else if (pushTakenW && !collSlotW)
    begin
      dirtyCount <= dirtyCount - 8'h01;
      cleanCount <= cleanCount + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack top and spill pointers.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      stackTopPointer <= PTR_RST;
      spillPointer    <= PTR_RST;
    end
    else if (idleW && cmdSetSpillPtr)
    begin
      spillPointer    <= newSpillPtr;
      stackTopPointer <= addSlots(newSpillPtr, dirtyCount);
    end
    else if (idleW && !cmdInvalidate && cmdPreserve && preserveSize <= frameSize)
      stackTopPointer <= addSlots(stackTopPointer, preserveSize);
    else if (pushTakenW)
      spillPointer <= spillPointer + WORD_BYTES;
  end

  // Token bit of each spilled register lands in its slot of the collection.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      deferredTokenCollection <= TOKEN_RST;
    else if (pushTakenW && !collSlotW)
      deferredTokenCollection[slotW] <= regReadToken;
  end

  // Frame load enable is set when the fill pointer check passes and cleared only by reset; no fill is started.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      currentFrameLoadEnable <= 1'b0;
    else if (idleW && cmdEnableFrameLoad && fillPointer > stackTopPointer)
      currentFrameLoadEnable <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  partition_sum_a: assert property (@(posedge clk) disable iff (sys_rst)
    ({1'b0, dirtyCount} + cleanCount + invalidCount + frameSize) == 9'(NSTK))
    else $error("Partition counters do not add up to the stacked registers.");

  frame_load_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    idleW && cmdEnableFrameLoad && fillPointer > stackTopPointer |=> currentFrameLoadEnable)
    else $error("Frame load enable not set after a high fill pointer.");

  frame_load_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    idleW && cmdEnableFrameLoad && !cmdNewFrame && !cmdSetSpillPtr
    |=> !spillFaulted && cmdReady && $stable(spillPointer))
    else $error("Enabling frame loads caused spill activity.");

  spill_outside_a: assert property (@(posedge clk) disable iff (sys_rst)
    pushW && !collSlotW |-> {1'b0, wrapAdd(nextSpillRegister, 8'(NSTK) - {1'b0, frameBase})} >= frameSize)
    else $error("Spill offered for a register inside the current frame.");

  invalidate_all_a: assert property (@(posedge clk) disable iff (sys_rst)
    idleW && cmdInvalidate && !cmdSetSpillPtr |=> dirtyCount == 8'h00 && cleanCount == 8'h00)
    else $error("Registers outside the frame survived invalidation.");

  preserve_base_a: assert property (@(posedge clk) disable iff (sys_rst)
    idleW && cmdPreserve && !cmdInvalidate && !cmdSetSpillPtr && preserveSize <= frameSize
    |=> frameBase == wrapAdd($past(frameBase), $past(preserveSize)))
    else $error("Frame base not renamed by the preserved count.");

  coll_word_a: assert property (@(posedge clk) disable iff (sys_rst)
    pushW && collSlotW |-> pushIf.data[SPILL_W-ADDR_W-1 -: DATA_W] == deferredTokenCollection)
    else $error("Collection slot did not carry the token collection.");

  ptr_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    pushTakenW |=> spillPointer == $past(spillPointer) + WORD_BYTES)
    else $error("Spill pointer did not advance by one word.");

  reg_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    pushTakenW && !collSlotW |=> dirtyCount == $past(dirtyCount) - 8'h01
    && cleanCount == $past(cleanCount) + 8'h01)
    else $error("Register spill did not move one register to clean.");

  spill_cfg_a: assert property (@(posedge clk) disable iff (sys_rst)
    pushW |-> pushIf.data[PL_W:0] == {spillPrivilegeLevel, spillByteOrder})
    else $error("Spill word lost the configured privilege or byte order.");

  rebase_top_a: assert property (@(posedge clk) disable iff (sys_rst)
    idleW && cmdSetSpillPtr |=> stackTopPointer == addSlots($past(newSpillPtr), dirtyCount)
    && cleanCount == 8'h00)
    else $error("Stack top not rebuilt from the new spill pointer.");
endmodule : rss_spill_engine
